// ===== fcs_consts.vh
/*
 * Sequencer constants: offsets, status bits, codes, pulse lengths.
 * Assumes inclusion by bare name.
 */
`ifndef FCS_CONSTS_VH
`define FCS_CONSTS_VH

// ****************************************************************
// Register map (byte addresses on the AXI4-Lite port)
// ****************************************************************
`define FCS_DIV_OFS      16'h0000
`define FCS_STAT_OFS     16'h0004
`define FCS_CMD_OFS      16'h0008
`define FCS_ARRAY_BIT    16
`define FCS_DIV_RST      8'h00
`define FCS_CMD_RST      8'h00

// ****************************************************************
// Status register fields
// ****************************************************************
`define FCS_ST_CBEF      7
`define FCS_ST_CCF       6
`define FCS_ST_ACCERR    4
`define FCS_ST_PUMP      0

// ****************************************************************
// Command codes
// ****************************************************************
`define FCS_CMD_BLANK    8'h05
`define FCS_CMD_BYTE     8'h20
`define FCS_CMD_BURST    8'h25
`define FCS_CMD_PAGE     8'h40
`define FCS_CMD_MASS     8'h41

// ****************************************************************
// Operation lengths in timing clock periods
// ****************************************************************
`define FCS_BYTE_TICKS   15'd9
`define FCS_BURST_TICKS  15'd4
`define FCS_PAGE_TICKS   15'd4000
`define FCS_MASS_TICKS   15'd20000
`define FCS_BLANK_TICKS  15'd1
`define FCS_PAGE_MASK    16'hFE00
`define FCS_ROW_BITS     6

// ****************************************************************
// AXI responses
// ****************************************************************
`define FCS_RESP_OKAY    2'b00
`define FCS_RESP_SLVERR  2'b10

`endif

// ===== fcs_sequencer.v
/*
 * Flash command sequencer: divider, status, command buffer, pulse timer.
 * Assumes an AXI4-Lite master on clk and stop/secure/debug pin levels.
 */
// Our own choices: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ps
`include "fcs_consts.vh"

module fcs_sequencer #(
    parameter [14:0] PAGE_TICKS = `FCS_PAGE_TICKS,
    parameter [14:0] MASS_TICKS = `FCS_MASS_TICKS
) (
    input  wire        clk,
    input  wire        rst_n,
    input  wire [19:0] s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output reg         s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output reg         s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [19:0] s_axi_araddr,
    input  wire        s_axi_arvalid,
    output reg         s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    input  wire        stop_mode,
    input  wire        part_secured,
    input  wire        debug_path,
    output reg         op_active,
    output reg  [7:0]  op_cmd,
    output reg  [15:0] op_addr,
    output reg  [7:0]  op_data,
    output reg         op_both_arrays,
    output reg         pump_on
);

    // Sequence states.
    localparam [1:0] SQ_IDLE = 2'd0;
    localparam [1:0] SQ_ADDR = 2'd1;
    localparam [1:0] SQ_CMD  = 2'd2;

    // ************************************************************
    // Helpers
    // ************************************************************
    // Tells whether a code is one of the five accepted commands.
    function valid_code;
        input [7:0] c;
        begin
            valid_code = (c == `FCS_CMD_BLANK) || (c == `FCS_CMD_BYTE) ||
                         (c == `FCS_CMD_BURST) || (c == `FCS_CMD_PAGE) ||
                         (c == `FCS_CMD_MASS);
        end
    endfunction
    reg        aw_got, w_got, div_done, tick, accerr, ccf, buf_full;
    reg        stop_m, stop_s, sec_m, sec_s, dbg_m, dbg_s;
    reg        err_set, launch, acc_clr, arr_take, cmd_take;
    reg [1:0]  seq, next_seq;
    reg [3:0]  ws;
    reg [7:0]  div, pre_cnt, buf_data, buf_cmd;
    reg [14:0] ex_cnt, start_ticks;
    reg [15:0] buf_addr;
    reg [19:0] wa;
    reg [31:0] wd;

    wire       do_wr   = aw_got & w_got & ~s_axi_bvalid;
    wire       wr_en   = do_wr & ws[0];
    wire       in_arr  = wa[`FCS_ARRAY_BIT];
    wire       hit_div = ~in_arr & (wa[15:0] == `FCS_DIV_OFS);
    wire       hit_st  = ~in_arr & (wa[15:0] == `FCS_STAT_OFS);
    wire       hit_cmd = ~in_arr & (wa[15:0] == `FCS_CMD_OFS);
    wire       wr_map  = in_arr | hit_div | hit_st | hit_cmd;
    wire       wr_arr  = wr_en & in_arr;
    wire       wr_div  = wr_en & hit_div;
    wire       wr_st   = wr_en & hit_st;
    wire       wr_cmd  = wr_en & hit_cmd;
    wire       cbef    = ~buf_full;
    wire       done    = op_active & tick & (ex_cnt == 15'd1);
    wire       abort   = op_active & stop_s &
                         (op_cmd != `FCS_CMD_BLANK);
    wire       start   = buf_full & ~op_active & ~accerr;
    wire       restrict_cmd = sec_s & dbg_s &
                         ((wd[7:0] == `FCS_CMD_BYTE) ||
                          (wd[7:0] == `FCS_CMD_BURST) ||
                          (wd[7:0] == `FCS_CMD_PAGE));
    wire [15:0] next_seq_addr = op_addr + 16'h0001;
    wire       keep    = (op_cmd == `FCS_CMD_BURST) & buf_full &
                         (buf_cmd == `FCS_CMD_BURST) &
                         (buf_addr == next_seq_addr) &
                         (|buf_addr[`FCS_ROW_BITS-1:0]);

    // ************************************************************
    // Pin synchronisers
    // ************************************************************
    // Two flip-flops for each level that arrives from outside.
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            {stop_m, sec_m, dbg_m} <= 3'b000;
            {stop_s, sec_s, dbg_s} <= 3'b000;
        end else begin
            {stop_m, sec_m, dbg_m} <= {stop_mode, part_secured, debug_path};
            {stop_s, sec_s, dbg_s} <= {stop_m, sec_m, dbg_m};
        end
    end

    // ************************************************************
    // AXI4-Lite slave
    // ************************************************************
    // Channels are taken in either order; bvalid two cycles after both.
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            {s_axi_awready, s_axi_wready} <= 2'b11;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `FCS_RESP_OKAY;
            {aw_got, w_got} <= 2'b00;
            wa            <= 20'h00000;
            wd            <= 32'h00000000;
            ws            <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_got        <= 1'b1;
                wa            <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_got        <= 1'b1;
                wd           <= s_axi_wdata;
                ws           <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (do_wr) begin
                {aw_got, w_got} <= 2'b00;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_map ? `FCS_RESP_OKAY : `FCS_RESP_SLVERR;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid  <= 1'b0;
                {s_axi_awready, s_axi_wready} <= 2'b11;
            end
        end
    end

    // Reads answer one cycle after the address is taken.
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            {s_axi_arready, s_axi_rvalid} <= 2'b10;
            s_axi_rdata   <= 32'h00000000;
            s_axi_rresp   <= `FCS_RESP_OKAY;
        end else begin
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid  <= 1'b1;
                s_axi_rresp   <= `FCS_RESP_OKAY;
                s_axi_rdata   <= 32'h00000000;
                if (s_axi_araddr[`FCS_ARRAY_BIT]) begin
                    s_axi_rresp <= `FCS_RESP_SLVERR;
                end else if (s_axi_araddr[15:0] == `FCS_DIV_OFS) begin
                    s_axi_rdata <= {23'h000000, div_done, div};
                end else if (s_axi_araddr[15:0] == `FCS_STAT_OFS) begin
                    s_axi_rdata <= {24'h000000, cbef, ccf, 1'b0, accerr,
                                    3'b000, pump_on};
                end else if (s_axi_araddr[15:0] == `FCS_CMD_OFS) begin
                    s_axi_rdata <= {24'h000000, buf_cmd};
                end else begin
                    s_axi_rresp <= `FCS_RESP_SLVERR;
                end
            end
            if (s_axi_rvalid && s_axi_rready) begin
                {s_axi_arready, s_axi_rvalid} <= 2'b10;
            end
        end
    end

    // ************************************************************
    // Command protocol checker
    // ************************************************************
    // Walks array write, command write and launch; flags misordering.
    always @* begin
        next_seq = seq;
        err_set  = abort;
        launch   = 1'b0;
        acc_clr  = wr_st & wd[`FCS_ST_ACCERR];
        arr_take = 1'b0;
        cmd_take = 1'b0;
        if (wr_arr && !accerr) begin
            if (!div_done || buf_full) begin
                err_set = 1'b1;
            end else if (seq != SQ_IDLE) begin
                err_set = 1'b1;
            end else begin
                arr_take = 1'b1;
                next_seq = SQ_ADDR;
            end
        end
        if (wr_cmd && !accerr) begin
            case (seq)
                SQ_ADDR: begin
                    if (!valid_code(wd[7:0])) begin
                        err_set = 1'b1;
                    end else if (restrict_cmd) begin
                        err_set = 1'b1;
                    end else begin
                        cmd_take = 1'b1;
                        next_seq = SQ_CMD;
                    end
                end
                SQ_CMD:  err_set = 1'b1;
                default: next_seq = seq;
            endcase
        end
        if (wr_st) begin
            case (seq)
                SQ_CMD: begin
                    if (wd[`FCS_ST_CBEF]) begin
                        launch   = 1'b1;
                        next_seq = SQ_IDLE;
                    end else begin
                        err_set = 1'b1;
                    end
                end
                SQ_ADDR: err_set = 1'b1;
                default: next_seq = seq;
            endcase
        end
        if (wr_div && seq != SQ_IDLE) begin
            err_set = 1'b1;
        end
        if (err_set) begin
            next_seq = SQ_IDLE;
        end
    end

    // Flags, sequence state and the command buffer.
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            seq      <= SQ_IDLE;
            {accerr, buf_full, div_done} <= 3'b000;
            ccf      <= 1'b1;
            buf_addr <= 16'h0000;
            buf_data <= 8'h00;
            buf_cmd  <= `FCS_CMD_RST;
            div      <= `FCS_DIV_RST;
        end else begin
            seq    <= next_seq;
            accerr <= err_set | (accerr & ~acc_clr);
            ccf    <= ~op_active & ~buf_full & ~launch;
            if (wr_div && !div_done && !accerr && seq == SQ_IDLE) begin
                div      <= wd[7:0];
                div_done <= 1'b1;
            end
            if (arr_take) begin
                buf_addr <= wa[15:0];
                buf_data <= wd[7:0];
            end
            if (cmd_take) begin
                buf_cmd <= wd[7:0];
            end
            if (launch) begin
                buf_full <= 1'b1;
            end else if (start || abort) begin
                buf_full <= 1'b0;
            end
        end
    end

    // ************************************************************
    // Timing clock and operation timer
    // ************************************************************
    // One tick every div+1 bus clocks once the divider is written.
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pre_cnt <= 8'h00;
            tick    <= 1'b0;
        end else if (!div_done) begin
            pre_cnt <= 8'h00;
            tick    <= 1'b0;
        end else if (pre_cnt == div) begin
            pre_cnt <= 8'h00;
            tick    <= 1'b1;
        end else begin
            pre_cnt <= pre_cnt + 8'h01;
            tick    <= 1'b0;
        end
    end

    // Length of the operation about to start, in timing periods.
    always @* begin
        case (buf_cmd)
            `FCS_CMD_BURST: start_ticks = pump_on ? `FCS_BURST_TICKS
                                                  : `FCS_BYTE_TICKS;
            `FCS_CMD_BYTE:  start_ticks = `FCS_BYTE_TICKS;
            `FCS_CMD_PAGE:  start_ticks = PAGE_TICKS;
            `FCS_CMD_MASS:  start_ticks = MASS_TICKS;
            default:        start_ticks = `FCS_BLANK_TICKS;
        endcase
    end

    // Runs one command; the pump stays on only for a queued same-row burst.
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            {op_active, op_both_arrays, pump_on} <= 3'b000;
            op_cmd         <= `FCS_CMD_RST;
            op_addr        <= 16'h0000;
            op_data        <= 8'h00;
            ex_cnt         <= 15'd0;
        end else if (abort) begin
            op_active <= 1'b0;
            pump_on   <= 1'b0;
        end else if (start) begin
            op_active <= 1'b1;
            op_cmd    <= buf_cmd;
            ex_cnt    <= start_ticks;
            pump_on   <= 1'b1;
            op_both_arrays <= (buf_cmd == `FCS_CMD_MASS) ||
                              (buf_cmd == `FCS_CMD_BLANK);
            if (buf_cmd == `FCS_CMD_PAGE) begin
                op_addr <= buf_addr & `FCS_PAGE_MASK;
                op_data <= 8'h00;
            end else if (buf_cmd == `FCS_CMD_BYTE ||
                         buf_cmd == `FCS_CMD_BURST) begin
                op_addr <= buf_addr;
                op_data <= buf_data;
            end else begin
                op_addr <= 16'h0000;
                op_data <= 8'h00;
            end
        end else if (done) begin
            op_active <= 1'b0;
            pump_on   <= keep;
        end else if (op_active) begin
            if (tick) begin
                ex_cnt <= ex_cnt - 15'd1;
            end
        end else begin
            pump_on <= 1'b0;
        end
    end

endmodule // fcs_sequencer

// ===== fcs_sequencer_sva.sv
/* Checker for the flash command sequencer ports.
   Assumes a bind into fcs_sequencer and a single clock domain. */
`timescale 1ns/1ps
`include "fcs_consts.vh"
module fcs_sequencer_sva (
    input wire logic        clk,
    input wire logic        rst_n,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic        s_axi_rvalid,
    input wire logic        stop_mode,
    input wire logic        op_active,
    input wire logic [7:0]  op_cmd,
    input wire logic [15:0] op_addr,
    input wire logic [7:0]  op_data,
    input wire logic        op_both_arrays,
    input wire logic        pump_on
);
    // ********************
    // Properties
    // ********************
    default clocking dck @(posedge clk); endclocking
    default disable iff (!rst_n);
    wire wide = (op_cmd == `FCS_CMD_MASS) || (op_cmd == `FCS_CMD_BLANK);
    wire prog = (op_cmd == `FCS_CMD_BYTE) || (op_cmd == `FCS_CMD_BURST);
    // Both halves of a write taken at one edge.
    sequence s_wr_take;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    // A program or erase running while stop is held for four cycles.
    sequence s_stop_run;
        (op_active && op_cmd != `FCS_CMD_BLANK && stop_mode)
            ##1 stop_mode [*3];
    endsequence
    a_write_answer: assert property (s_wr_take |-> ##2 s_axi_bvalid)
        else $error("write response not on time");
    a_resp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp not held");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=>
        s_axi_rvalid) else $error("read response not on time");
    a_code_valid: assert property ($rose(op_active) |->
        wide || prog || op_cmd == `FCS_CMD_PAGE) else $error("bad code run");
    a_page_aligned: assert property (op_active &&
        op_cmd == `FCS_CMD_PAGE |-> op_addr[8:0] == 9'h000)
        else $error("page erase address not aligned");
    a_erase_nodata: assert property (op_active && !prog |->
        op_data == 8'h00) else $error("erase carries data");
    a_array_span: assert property (op_active |->
        op_both_arrays == wide) else $error("wrong array span");
    a_stop_abort: assert property (s_stop_run |-> ##[0:2] !op_active)
        else $error("stop did not abort");
    a_pump_idle: assert property (!op_active [*4] |-> !pump_on)
        else $error("pump left on while idle");
endmodule // fcs_sequencer_sva

bind fcs_sequencer fcs_sequencer_sva chk_u (
    .clk(clk), .rst_n(rst_n), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rvalid(s_axi_rvalid), .stop_mode(stop_mode),
    .op_active(op_active), .op_cmd(op_cmd), .op_addr(op_addr),
    .op_data(op_data), .op_both_arrays(op_both_arrays), .pump_on(pump_on)
);

// ===== fcs_axi_master.sv
/* Bus master model standing for the CPU or the debug controller.
   Assumes an AXI4-Lite slave on the same clock; the bench calls
   the tasks one at a time. */
`timescale 1ns/1ps
module fcs_axi_master (
    input  wire logic        clk,
    output logic [19:0] awaddr,
    output logic        awvalid,
    input  wire logic        awready,
    output logic [31:0] wdata,
    output logic        wvalid,
    input  wire logic        wready,
    input  wire logic        bvalid,
    output logic        bready,
    output logic [19:0] araddr,
    output logic        arvalid,
    input  wire logic        arready,
    input  wire logic [31:0] rdata,
    input  wire logic [1:0]  rresp,
    input  wire logic        rvalid,
    output logic        rready
);
    // ********************
    // Bus tasks
    // ********************
    // Bus idles at time zero.
    initial begin
        {awaddr, awvalid, wdata, wvalid, bready} = '0;
        {araddr, arvalid, rready} = '0;
    end
    // One write; released lines show the inverse so stale values fail.
    task wr(input logic [19:0] a, input logic [31:0] d);
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge clk);
            if (awvalid && awready) begin
                awvalid <= 1'b0;
                awaddr <= ~a;
            end
            if (wvalid && wready) begin
                wvalid <= 1'b0;
                wdata <= ~d;
            end
        end while ((awvalid && !awready) || (wvalid && !wready));
        while (!bvalid) @(posedge clk);
        bready <= 1'b0;
    endtask
    // One read; data and response are taken at the rvalid edge.
    task rd(input logic [19:0] a, output logic [31:0] d,
            output logic [1:0] r);
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge clk); while (!arready);
        arvalid <= 1'b0;
        araddr <= ~a;
        do @(posedge clk); while (!rvalid);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask
endmodule // fcs_axi_master

// ===== fcs_sequencer_tb_top.sv
/* Self-checking bench for the flash command sequencer.
   Assumes the master model and the bound checker compile first. */
`timescale 1ns/1ps
`include "fcs_consts.vh"
module fcs_sequencer_tb_top;
    // ********************
    // Set-up
    // ********************
    localparam [14:0] PT = 15'd20;
    localparam [14:0] MT = 15'd40;
    localparam [7:0]  DIV = 8'hF9; // 50 MHz / 250 gives 200 kHz.
    localparam [19:0] A_DIV = {4'h0, `FCS_DIV_OFS};
    localparam [19:0] A_ST = {4'h0, `FCS_STAT_OFS};
    localparam [19:0] A_CMD = {4'h0, `FCS_CMD_OFS};
    logic        clk, rst_n, stop_mode, part_secured, debug_path;
    logic [19:0] awaddr, araddr;
    logic [31:0] wdata, rdata, d;
    logic [1:0]  rresp, r;
    logic        awvalid, awready, wvalid, wready, bvalid, bready;
    logic        arvalid, arready, rvalid, rready, op_active, pump_on;
    logic        op_both_arrays, last_act, last_pump;
    logic [7:0]  op_cmd, op_data, c, dv;
    logic [15:0] op_addr, last_addr, a;
    logic [7:0]  codes [5] = '{`FCS_CMD_BLANK, `FCS_CMD_BYTE,
                               `FCS_CMD_BURST, `FCS_CMD_PAGE, `FCS_CMD_MASS};
    int          errors, compares, cycles, run, drops, d0, i, k, seed;
    int          durs [$];

    fcs_sequencer #(.PAGE_TICKS(PT), .MASS_TICKS(MT)) dut_u (
        .clk(clk), .rst_n(rst_n), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .stop_mode(stop_mode),
        .part_secured(part_secured), .debug_path(debug_path),
        .op_active(op_active), .op_cmd(op_cmd), .op_addr(op_addr),
        .op_data(op_data), .op_both_arrays(op_both_arrays),
        .pump_on(pump_on));
    fcs_axi_master m_u (
        .clk(clk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wvalid(wvalid), .wready(wready), .bvalid(bvalid),
        .bready(bready), .araddr(araddr), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
        .rready(rready));

    // Free-running bench clock.
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // Logs each operation's length, counts pump drops, cuts a hang.
    always @(posedge clk) begin
        if (last_act && (!op_active || op_addr !== last_addr)) begin
            durs.push_back(run);
            run = 0;
        end
        if (op_active) run++;
        if (last_pump && !pump_on) drops++;
        last_act = op_active;
        last_pump = pump_on;
        last_addr = op_addr;
        cycles++;
        if (cycles == 60000) begin
            errors++;
            $display("[FAIL] %0t: run too long", $time);
            results;
        end
    end

    // ********************
    // Helpers
    // ********************
    function int ticks(input logic [7:0] cc);
        if (cc == `FCS_CMD_PAGE) return PT;
        if (cc == `FCS_CMD_MASS) return MT;
        return (cc == `FCS_CMD_BLANK) ? 1 : 9;
    endfunction
    function bit fits(input int n, input int t);
        return n >= t * 250 - 249 && n <= t * 250 + 2;
    endfunction
    function logic [15:0] exp_addr(input logic [7:0] cc, input logic [15:0] aa);
        if (cc == `FCS_CMD_PAGE) return aa & 16'hFE00;
        return (cc == `FCS_CMD_MASS || cc == `FCS_CMD_BLANK) ? 16'h0 : aa;
    endfunction
    task chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task seq(input logic [7:0] cc, input logic [15:0] aa, input logic [7:0] dd);
        m_u.wr({4'h1, aa}, {24'h0, dd});
        m_u.wr(A_CMD, {24'h0, cc});
        m_u.wr(A_ST, 32'h80);
    endtask
    task stat(input logic e);
        m_u.rd(A_ST, d, r);
        chk(d[4], e);
    endtask
    task wait_start(input logic [15:0] aa);
        for (int n = 0; n < 3000 && !(op_active && op_addr === aa); n++)
            @(posedge clk);
        chk({op_active, op_addr}, {1'b1, aa});
    endtask
    task wait_end;
        for (int n = 0; n < 12000 && op_active !== 1'b0; n++) @(posedge clk);
        repeat (3) @(posedge clk);
        chk(op_active, 1'b0);
    endtask
    task results;
        $display("errors=%0d compares=%0d", errors, compares);
        if (errors == 0 && compares > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    // ********************
    // Scenarios
    // ********************
    initial begin
        {rst_n, stop_mode, part_secured, debug_path} = 4'h0;
        seed = 32'h0c01;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        m_u.rd(A_ST, d, r);
        chk(d[7:0] & 8'hD1, 8'hC0);
        m_u.rd(20'h0000C, d, r);
        chk(r, `FCS_RESP_SLVERR);
        m_u.wr(20'h10123, 32'h11);
        stat(1'b1);
        m_u.wr(A_DIV, 32'h05);
        m_u.rd(A_DIV, d, r);
        chk(d[8], 1'b0);
        m_u.wr(A_ST, 32'h10);
        stat(1'b0);
        m_u.wr(A_DIV, {24'h0, DIV});
        m_u.wr(A_DIV, 32'h10);
        m_u.rd(A_DIV, d, r);
        chk(d[8:0], {1'b1, DIV});
        for (i = 0; i < 5; i++) begin
            a = 16'($random(seed));
            dv = 8'($random(seed));
            c = codes[i];
            durs.delete();
            seq(c, a, dv);
            wait_start(exp_addr(c, a));
            chk(op_cmd, c);
            chk(op_data, (c == `FCS_CMD_BYTE || c == `FCS_CMD_BURST) ? dv : 8'h0);
            chk(op_both_arrays, c == `FCS_CMD_MASS || c == `FCS_CMD_BLANK);
            wait_end;
            chk(fits(durs[0], ticks(c)), 1'b1);
            m_u.rd(A_ST, d, r);
            chk(d[6], 1'b1);
        end
        durs.delete();
        d0 = drops;
        seq(`FCS_CMD_BURST, 16'h003E, 8'hA1);
        wait_start(16'h003E);
        m_u.rd(A_ST, d, r);
        chk(d[7], 1'b1);
        seq(`FCS_CMD_BURST, 16'h003F, 8'hA2);
        wait_start(16'h003F);
        seq(`FCS_CMD_BURST, 16'h0040, 8'hA3);
        wait_start(16'h0040);
        wait_end;
        chk(fits(durs[0], 9) && fits(durs[1], 4), 1'b1);
        chk(fits(durs[2], 9), 1'b1);
        chk(drops - d0, 2);
        for (k = 0; k < 6; k++) begin
            do c = 8'($random(seed)); while (c inside {codes});
            a = 16'($random(seed));
            m_u.wr({4'h1, a}, 32'h33);
            case (k)
                0: m_u.wr(A_ST, 32'h0);
                1: m_u.wr({4'h1, a}, 32'h0);
                2: m_u.wr(A_CMD, {24'h0, c});
                3: m_u.wr(A_DIV, 32'h1);
                default: begin
                    m_u.wr(A_CMD, 32'h20);
                    m_u.wr(k == 4 ? A_CMD : A_DIV, 32'h20);
                end
            endcase
            stat(1'b1);
            seq(`FCS_CMD_BYTE, a, 8'h44);
            repeat (20) @(posedge clk);
            chk(op_active, 1'b0);
            m_u.wr(A_ST, 32'h10);
            stat(1'b0);
        end
        a = 16'($random(seed));
        seq(`FCS_CMD_PAGE, a, 8'h0);
        wait_start(a & 16'hFE00);
        stop_mode <= 1'b1;
        repeat (6) @(posedge clk);
        chk(op_active, 1'b0);
        stop_mode <= 1'b0;
        stat(1'b1);
        m_u.wr(A_ST, 32'h10);
        part_secured <= 1'b1;
        debug_path <= 1'b1;
        repeat (4) @(posedge clk);
        for (i = 0; i < 5; i++) begin
            c = codes[i];
            seq(c, 16'h0200, 8'h5A);
            if (c == `FCS_CMD_BLANK || c == `FCS_CMD_MASS) begin
                wait_start(16'h0000);
                wait_end;
                stat(1'b0);
            end else begin
                repeat (20) @(posedge clk);
                chk(op_active, 1'b0);
                stat(1'b1);
                m_u.wr(A_ST, 32'h10);
            end
        end
        results;
    end
endmodule // fcs_sequencer_tb_top
